// file: awp_window_positioner.sv
// Purpose: horizontal acquisition window settings, apb register front end
// Assumes: trig is a synchronous one-cycle trigger event
// Notes:   times in ps, duration write searches the nearest legal step
// Summary of operation
// - record length 256 up to 15000 real-time, 30000 extended real-time
// - one trigger fires the same window on every active channel together
// - length 30000 forced to 15000 when interval change enters real-time
// - real-time below 100 ns per point, extended otherwise, nothing else
// - first sample time is offset minus anchor times duration
// - point offset clamped to anchor*length down to that minus length
// - time offset clamped to anchor*duration down to that minus duration
// - anchor given as fraction 0..1 or percent 1..100, or min/max
// - duration accepted from 51.2 ns to 6000 s, or min/max
// - interval accepted only on legal steps, or min/max
// - duration with length derives interval rounded to nearest step
// - duration always equals interval times length
// - trigger may sit at any sample position within the record
// - interval in seconds by default, ms, us, ns, ps multipliers accepted
// - trigger instant is time zero, samples timed relative to it
`timescale 1ns/10ps
module awp_window_positioner
  import awp_pkg::*;
#(
  parameter int NCH = 4
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // trigger and channels
  input  wire logic              trig,
  output logic [NCH-1:0]         chan_fire,
  // window handed to the acquisition path
  output logic                   acq_start,
  output logic                   acq_rt,
  output logic [LW-1:0]          acq_len,
  output logic [SW-1:0]          acq_step,
  output logic signed [TW-1:0]   acq_first_time
);
  awp_search_if sr ();

  awp_state_type        state_q, state_d;
  logic [SW-1:0]        step_q, step_d;
  logic [LW-1:0]        len_q, len_d;
  logic [TW-1:0]        dur_q, dur_d;
  logic [AW-1:0]        anchor_q, anchor_d;
  logic signed [TW-1:0] ofs_q, ofs_d;
  logic signed [31:0]   pts_q, pts_d;
  logic [31:0]          dlo_q, dlo_d;
  logic [31:0]          olo_q, olo_d;
  logic [EW-1:0]        err_q, err_d;
  logic [NCH-1:0]       chen_q, chen_d;
  logic [NCH-1:0]       snap_en_q, snap_en_d;
  logic                 armed_q, armed_d;
  logic                 start_q, start_d;
  logic [NCH-1:0]       fire_q, fire_d;
  logic                 srt_q, srt_d;
  logic [LW-1:0]        slen_q, slen_d;
  logic [SW-1:0]        sstep_q, sstep_d;
  logic signed [TW-1:0] sfirst_q, sfirst_d;
  logic [31:0]          rdata_q, rdata_d;

  logic                 wr_done;
  logic                 hi_acc;
  logic                 rt_now;
  logic [LW-1:0]        len_lim;
  logic [TW-1:0]        anc_dur;
  logic signed [TW-1:0] anc_len;
  logic signed [TW-1:0] first_t;
  logic [EW-1:0]        err_set, err_clr;

  function automatic logic addr_ok(input logic [7:0] a);
    return a <= REG_CHAN_EN && a[1:0] == 2'b00;
  endfunction : addr_ok

  // derived window
  assign rt_now  = is_rt(step_q);
  assign len_lim = rt_now ? LEN_RT_MAX : LEN_ERT_MAX;
  assign anc_dur = TW'(({14'h0, dur_q} * anchor_q) / ANCHOR_ONE);
  assign anc_len = TW'((len_q * anchor_q) / ANCHOR_ONE);
  assign first_t = ofs_q - $signed(anc_dur);

  // duration write stalls pready while the step search runs
  assign hi_acc  = psel && penable && pwrite && paddr == REG_DUR_HI;
  assign pready  = !(hi_acc && state_q != S_FIN);
  assign wr_done = psel && penable && pwrite && pready;
  assign pslverr = psel && penable && !addr_ok(paddr);

  always_comb begin
    logic [TW-1:0]        tgt;
    logic [TW-1:0]        ask;
    logic [SW-1:0]        s;
    logic [LW-1:0]        l;
    logic                 hit;
    logic                 do_step;
    logic [AW-1:0]        av;
    logic signed [TW-1:0] p;
    logic signed [TW-1:0] tv;
    tgt     = '0;
    ask     = '0;
    s       = step_q;
    l       = len_q;
    hit     = 1'b0;
    do_step = 1'b0;
    av      = '0;
    p       = '0;
    tv      = '0;
    state_d = state_q;
    step_d  = step_q;
    len_d   = len_q;
    dur_d   = dur_q;
    anchor_d = anchor_q;
    ofs_d   = ofs_q;
    pts_d   = pts_q;
    dlo_d   = dlo_q;
    olo_d   = olo_q;
    chen_d  = chen_q;
    err_set = '0;
    err_clr = '0;
    sr.go   = 1'b0;
    sr.dur  = '0;
    sr.len  = len_q;

    unique case (state_q)
      S_IDLE: begin
        if (hi_acc) begin
          if (pwdata[F_DMIN]) tgt = DUR_MIN_PS;
          else if (pwdata[F_DMAX]) tgt = DUR_MAX_PS;
          else tgt = {pwdata[23:0], dlo_q};
          if (tgt < DUR_MIN_PS || tgt > DUR_MAX_PS) begin
            err_set[E_DURATION] = 1'b1;
            state_d = S_FIN;
          end else begin
            sr.go   = 1'b1;
            sr.dur  = tgt;
            state_d = S_RUN;
          end
        end
      end
      S_RUN: begin
        if (sr.done) begin
          s       = sr.idx;
          do_step = 1'b1;
          state_d = S_FIN;
        end
      end
      S_FIN: begin
        if (wr_done) state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase

    if (wr_done) begin
      unique case (paddr)
        REG_INTERVAL: begin
          // legal steps only, value scaled by its unit
          if (pwdata[F_KMIN]) begin
            s = STEP_MIN;
            do_step = 1'b1;
          end else if (pwdata[F_KMAX]) begin
            s = STEP_MAX;
            do_step = 1'b1;
          end else begin
            ask = TW'(pwdata[15:0] * unit_ps(pwdata[18:16]));
            for (int i = 0; i < STEP_N; i++) begin
              if (!hit && step_ps(SW'(i)) == ask) begin
                hit = 1'b1;
                s   = SW'(i);
              end
            end
            do_step = hit;
            err_set[E_INTERVAL] = !hit;
          end
        end
        REG_LENGTH: begin
          if (pwdata[F_KMIN]) l = LEN_MIN;
          else if (pwdata[F_KMAX]) l = len_lim;
          else l = pwdata[LW-1:0];
          if (l >= LEN_MIN && l <= len_lim) begin
            len_d = l;
            dur_d = TW'(step_ps(step_q) * l);
          end else begin
            err_set[E_LENGTH] = 1'b1;
          end
        end
        REG_DUR_LO: dlo_d = pwdata;
        REG_ANCHOR: begin
          if (pwdata[F_KMIN]) av = pwdata[F_PCT] ? PCT_MIN * PCT_SCALE : '0;
          else if (pwdata[F_KMAX]) av = ANCHOR_ONE;
          else if (pwdata[F_PCT]) av = AW'(pwdata[6:0] * PCT_SCALE);
          else av = pwdata[AW-1:0];
          if (pwdata[F_PCT] && !pwdata[F_KMIN] && !pwdata[F_KMAX]
              && (pwdata[13:0] < PCT_MIN || pwdata[13:0] > PCT_SCALE))
            err_set[E_ANCHOR] = 1'b1;
          else if (av > ANCHOR_ONE)
            err_set[E_ANCHOR] = 1'b1;
          else
            anchor_d = av;
        end
        REG_OFS_PTS: begin
          p = TW'($signed(pwdata));
          if (p > anc_len) p = anc_len;
          if (p < anc_len - $signed({40'h0, len_q}))
            p = anc_len - $signed({40'h0, len_q});
          pts_d = 32'(p);
          ofs_d = TW'(p * $signed({1'b0, step_ps(step_q)}));
        end
        REG_OFS_T_LO: olo_d = pwdata;
        REG_OFS_T_HI: begin
          tv = {pwdata[23:0], olo_q};
          if (tv > $signed(anc_dur)) tv = $signed(anc_dur);
          if (tv < $signed(anc_dur) - $signed(dur_q))
            tv = $signed(anc_dur) - $signed(dur_q);
          ofs_d = tv;
        end
        REG_STATUS:  err_clr = pwdata[EW-1:0];
        REG_CHAN_EN: chen_d = pwdata[NCH-1:0];
        default: ;
      endcase
    end

    // a new step may force a shorter record in real-time
    if (do_step) begin
      l = len_q;
      if (is_rt(s) && l > LEN_RT_MAX) l = LEN_RT_MAX;
      step_d = s;
      len_d  = l;
      dur_d  = TW'(step_ps(s) * l);
    end
    // set beats clear when both land together
    err_d = (err_q & ~err_clr) | err_set;
  end

  // start snapshot and trigger fan-out
  always_comb begin
    armed_d   = armed_q;
    start_d   = 1'b0;
    fire_d    = '0;
    srt_d     = srt_q;
    slen_d    = slen_q;
    sstep_d   = sstep_q;
    sfirst_d  = sfirst_q;
    snap_en_d = snap_en_q;
    if (wr_done && paddr == REG_CTRL && pwdata[F_START]) begin
      // running record keeps its window until this point
      armed_d   = 1'b1;
      start_d   = 1'b1;
      srt_d     = rt_now;
      slen_d    = len_q;
      sstep_d   = step_q;
      sfirst_d  = first_t;
      snap_en_d = chen_q;
    end else if (armed_q && trig) begin
      armed_d = 1'b0;
      fire_d  = snap_en_q;
    end
  end

  // read data captured in the setup phase
  always_comb begin
    rdata_d = rdata_q;
    if (psel && !penable) begin
      unique case (paddr)
        REG_CTRL:     rdata_d = {29'h0, state_q != S_IDLE, rt_now, armed_q};
        REG_INTERVAL: rdata_d = {27'h0, step_q};
        REG_LENGTH:   rdata_d = {16'h0, len_q};
        REG_DUR_LO:   rdata_d = dur_q[31:0];
        REG_DUR_HI:   rdata_d = {8'h0, dur_q[TW-1:32]};
        REG_ANCHOR:   rdata_d = {18'h0, anchor_q};
        REG_OFS_PTS:  rdata_d = pts_q;
        REG_OFS_T_LO: rdata_d = ofs_q[31:0];
        REG_OFS_T_HI: rdata_d = 32'(ofs_q[TW-1:32]);
        REG_FIRST_LO: rdata_d = first_t[31:0];
        REG_FIRST_HI: rdata_d = 32'(first_t[TW-1:32]);
        REG_STATUS:   rdata_d = {28'h0, err_q};
        REG_CHAN_EN:  rdata_d = 32'(chen_q);
        default:      rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= S_IDLE;
      step_q    <= STEP_MIN;
      len_q     <= LEN_MIN;
      dur_q     <= TW'(DUR_MIN_PS);
      anchor_q  <= '0;
      ofs_q     <= '0;
      pts_q     <= '0;
      dlo_q     <= '0;
      olo_q     <= '0;
      err_q     <= '0;
      chen_q    <= '1;
      snap_en_q <= '0;
      armed_q   <= 1'b0;
      start_q   <= 1'b0;
      fire_q    <= '0;
      srt_q     <= 1'b0;
      slen_q    <= '0;
      sstep_q   <= '0;
      sfirst_q  <= '0;
      rdata_q   <= '0;
    end else begin
      state_q   <= state_d;
      step_q    <= step_d;
      len_q     <= len_d;
      dur_q     <= dur_d;
      anchor_q  <= anchor_d;
      ofs_q     <= ofs_d;
      pts_q     <= pts_d;
      dlo_q     <= dlo_d;
      olo_q     <= olo_d;
      err_q     <= err_d;
      chen_q    <= chen_d;
      snap_en_q <= snap_en_d;
      armed_q   <= armed_d;
      start_q   <= start_d;
      fire_q    <= fire_d;
      srt_q     <= srt_d;
      slen_q    <= slen_d;
      sstep_q   <= sstep_d;
      sfirst_q  <= sfirst_d;
      rdata_q   <= rdata_d;
    end
  end

  awp_step_search u_search (
    .clk (clk),
    .rst (rst),
    .sr  (sr)
  );

  assign prdata         = rdata_q;
  assign chan_fire      = fire_q;
  assign acq_start      = start_q;
  assign acq_rt         = srt_q;
  assign acq_len        = slen_q;
  assign acq_step       = sstep_q;
  assign acq_first_time = sfirst_q;
endmodule : awp_window_positioner

// file: awp_pkg.sv
// Purpose: constants and helpers for the acquisition window positioner
// Assumes: time values held in picoseconds, anchor in 1/10000 of a record
// Notes:   register offsets are byte addresses on a 32-bit apb
package awp_pkg;
  localparam int TW = 56;
  localparam int LW = 16;
  localparam int SW = 5;
  localparam int AW = 14;
  localparam int STEP_N = 28;
  localparam logic [SW-1:0] STEP_MAX = 5'h1B;
  localparam logic [SW-1:0] STEP_MIN = 5'h00;
  localparam logic [TW-1:0] RT_LIMIT_NS = 56'h64;
  localparam logic [TW-1:0] RT_LIMIT_PS = RT_LIMIT_NS * 56'h3E8;
  localparam logic [LW-1:0] LEN_MIN = 16'h0100;
  localparam logic [LW-1:0] LEN_RT_MAX = 16'h3A98;
  localparam logic [LW-1:0] LEN_ERT_MAX = 16'h7530;
  localparam logic [TW-1:0] PS_PER_S = 56'hE8D4A51000;
  localparam logic [TW-1:0] DUR_MIN_PS = 56'hC800;
  localparam logic [TW-1:0] DUR_MAX_S = 56'h1770;
  localparam logic [TW-1:0] DUR_MAX_PS = TW'(DUR_MAX_S * PS_PER_S);
  localparam logic [AW-1:0] ANCHOR_ONE = 14'h2710;
  localparam logic [AW-1:0] PCT_SCALE = 14'h0064;
  localparam logic [AW-1:0] PCT_MIN = 14'h0001;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INTERVAL = 8'h04;
  localparam logic [7:0] REG_LENGTH = 8'h08;
  localparam logic [7:0] REG_DUR_LO = 8'h0C;
  localparam logic [7:0] REG_DUR_HI = 8'h10;
  localparam logic [7:0] REG_ANCHOR = 8'h14;
  localparam logic [7:0] REG_OFS_PTS = 8'h18;
  localparam logic [7:0] REG_OFS_T_LO = 8'h1C;
  localparam logic [7:0] REG_OFS_T_HI = 8'h20;
  localparam logic [7:0] REG_FIRST_LO = 8'h24;
  localparam logic [7:0] REG_FIRST_HI = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2C;
  localparam logic [7:0] REG_CHAN_EN = 8'h30;
  // field positions
  localparam int F_START = 0;
  localparam int F_PCT = 16;
  localparam int F_KMIN = 20;
  localparam int F_KMAX = 21;
  localparam int F_DMIN = 30;
  localparam int F_DMAX = 31;
  localparam int E_INTERVAL = 0;
  localparam int E_LENGTH = 1;
  localparam int E_DURATION = 2;
  localparam int E_ANCHOR = 3;
  localparam int EW = 4;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_FIN} awp_state_type;

  // legal steps: 2,4,10 x 10^n ps from 200 ps up to 200 ms
  function automatic logic [TW-1:0] step_ps(input logic [SW-1:0] idx);
    logic [SW:0]   k;
    logic [SW:0]   dec;
    logic [TW-1:0] v;
    k   = {1'b0, idx} + 6'h01;
    dec = k / 6'h03;
    unique case (k % 6'h03)
      6'h01:   v = 56'h2;
      6'h02:   v = 56'h4;
      default: v = 56'h1;
    endcase
    for (int i = 0; i < 12; i++) begin
      if (i < int'(dec) + 2) v = TW'(v * 56'hA);
    end
    return v;
  endfunction : step_ps

  function automatic logic [TW-1:0] unit_ps(input logic [2:0] u);
    unique case (u)
      3'h0:    return PS_PER_S;
      3'h1:    return 56'h3B9ACA00;
      3'h2:    return 56'h0F4240;
      3'h3:    return 56'h03E8;
      3'h4:    return 56'h1;
      default: return 56'h0;
    endcase
  endfunction : unit_ps

  function automatic logic is_rt(input logic [SW-1:0] idx);
    return step_ps(idx) < RT_LIMIT_PS;
  endfunction : is_rt
endpackage : awp_pkg

// file: awp_search_if.sv
// Purpose: carries a nearest-step search request and its result
// Assumes: one requester, one search engine
// Notes:   dur and len are sampled only on go
`timescale 1ns/10ps
interface awp_search_if;
  import awp_pkg::*;
  logic          go;
  logic [TW-1:0] dur;
  logic [LW-1:0] len;
  logic          done;
  logic [SW-1:0] idx;
  modport req (output go, dur, len, input done, idx);
  modport eng (input go, dur, len, output done, idx);
endinterface : awp_search_if

// file: awp_step_search.sv
// Purpose: finds the legal sample step whose record duration is nearest
// Assumes: go pulsed once per search, dur and len latched then, not held by the caller
// Notes:   one multiplier reused over STEP_N cycles instead of STEP_N copies
`timescale 1ns/10ps
module awp_step_search
  import awp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // request
  awp_search_if.eng sr
);
  logic          run_q, run_d;
  logic          done_q, done_d;
  logic [SW-1:0] cnt_q, cnt_d;
  logic [SW-1:0] best_q, best_d;
  logic [TW-1:0] bdiff_q, bdiff_d;
  logic [TW-1:0] dur_q, dur_d;
  logic [LW-1:0] len_q, len_d;
  logic [TW-1:0] prod;
  logic [TW-1:0] diff;

  always_comb begin
    run_d   = run_q;
    done_d  = done_q;
    cnt_d   = cnt_q;
    best_d  = best_q;
    bdiff_d = bdiff_q;
    dur_d   = dur_q;
    len_d   = len_q;
    prod    = TW'(step_ps(cnt_q) * len_q);
    diff    = (dur_q >= prod) ? dur_q - prod : prod - dur_q;
    if (sr.go && !run_q) begin
      run_d   = 1'b1;
      done_d  = 1'b0;
      cnt_d   = STEP_MIN;
      bdiff_d = '1;
      dur_d   = sr.dur;
      len_d   = sr.len;
    end else if (run_q) begin
      // strict compare: a tie keeps the shorter step
      if (diff < bdiff_q) begin
        bdiff_d = diff;
        best_d  = cnt_q;
      end
      if (cnt_q == STEP_MAX) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= '0;
      best_q  <= '0;
      bdiff_q <= '0;
      dur_q   <= '0;
      len_q   <= '0;
    end else begin
      run_q   <= run_d;
      done_q  <= done_d;
      cnt_q   <= cnt_d;
      best_q  <= best_d;
      bdiff_q <= bdiff_d;
      dur_q   <= dur_d;
      len_q   <= len_d;
    end
  end

  assign sr.done = done_q;
  assign sr.idx  = best_q;
endmodule : awp_step_search

// file: awp_monitor.sv
// Purpose: port checks for the window positioner
// Assumes: one clock domain, rst async active high
// Notes:   bound into every positioner instance
`timescale 1ns/10ps
module awp_monitor
  import awp_pkg::*;
#(
  parameter int NCH = 4
)(
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // trigger and window
  input wire logic                   trig,
  input wire logic [NCH-1:0]         chan_fire,
  input wire logic                   acq_start,
  input wire logic                   acq_rt,
  input wire logic [LW-1:0]          acq_len,
  input wire logic [SW-1:0]          acq_step,
  input wire logic signed [TW-1:0]   acq_first_time
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_fire_cause;
    (|chan_fire) |-> $past(trig);
  endproperty
  a_fire_cause: assert property (p_fire_cause)
    else $error("channel fire without trigger");
  property p_fire_once;
    (|chan_fire) |=> !(|chan_fire);
  endproperty
  a_fire_once: assert property (p_fire_once)
    else $error("channel fire longer than one cycle");
  // snapshot moves only with a start, never mid-record
  property p_snap_hold;
    $changed({acq_len, acq_step, acq_rt, acq_first_time}) |-> acq_start;
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("window changed without start");
  property p_len_range;
    acq_start |-> acq_len >= LEN_MIN
      && acq_len <= (acq_rt ? LEN_RT_MAX : LEN_ERT_MAX);
  endproperty
  a_len_range: assert property (p_len_range)
    else $error("record length out of range");
  property p_rt_thresh;
    acq_start |-> acq_rt == (acq_step < 5'h08);
  endproperty
  a_rt_thresh: assert property (p_rt_thresh)
    else $error("sampling mode wrong for step");
  property p_step_legal;
    acq_start |-> acq_step <= STEP_MAX;
  endproperty
  a_step_legal: assert property (p_step_legal)
    else $error("illegal step index");
  property p_start_cause;
    acq_start |-> $past(psel && penable && pready && pwrite
      && paddr == REG_CTRL && pwdata[F_START]);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without start write");
  property p_search_bound;
    (psel && penable && !pready) |-> ##[1:31] pready;
  endproperty
  a_search_bound: assert property (p_search_bound)
    else $error("step search wait too long");
  property p_err_map;
    (psel && penable) |-> pslverr == (paddr > 8'h30 || paddr[1:0] != 2'h0);
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("slave error mismatch");
endmodule : awp_monitor

bind awp_window_positioner awp_monitor #(.NCH(NCH)) u_mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trig(trig), .chan_fire(chan_fire),
  .acq_start(acq_start), .acq_rt(acq_rt), .acq_len(acq_len),
  .acq_step(acq_step), .acq_first_time(acq_first_time)
);

// file: awp_ctrl_model.sv
// Purpose: remote controller model, apb master
// Assumes: slave answer time unknown, waits on pready
// Notes:   released address and data are inverted, never left stale
`timescale 1ns/10ps
module awp_ctrl_model (
  // clock
  input wire logic          clk,
  // apb master
  output logic              psel,
  output logic              penable,
  output logic              pwrite,
  output logic [7:0]        paddr,
  output logic [31:0]       pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : awp_ctrl_model

// file: awp_window_positioner_tb.sv
// Purpose: self-checking bench for the window positioner
// Assumes: controller model drives apb, bench drives trig
// Notes:   times in ps, expected values worked out by hand
`timescale 1ns/10ps
module awp_window_positioner_tb;
  import awp_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, trig;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] chan_fire;
  logic acq_start, acq_rt, e;
  logic [LW-1:0] acq_len;
  logic [SW-1:0] acq_step;
  logic signed [TW-1:0] acq_first_time;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // interval writes: unit/value and expected step index
  logic [31:0] iv [9] = '{32'h000100C8, 32'h00020064, 32'h0003000A,
    32'h00040190, 32'h00030028, 32'h00100000, 32'h00200000,
    32'h00030064, 32'h00000001};
  logic [4:0] ix [9] = '{5'h1B, 5'h11, 5'h05, 5'h01, 5'h07, 5'h00,
    5'h1B, 5'h08, 5'h08};
  awp_ctrl_model ctl (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  awp_window_positioner DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig(trig),
    .chan_fire(chan_fire), .acq_start(acq_start), .acq_rt(acq_rt),
    .acq_len(acq_len), .acq_step(acq_step),
    .acq_first_time(acq_first_time));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // plenty of margin over the longest sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [63:0] s, x);
    n_compared++;
    if (s !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ctl.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a,
    input logic [31:0] x);
    ctl.xfer(1'b0, a, 32'h0, q, e);
    chk(n, q, x);
  endtask : rc
  task automatic pulse(input logic [3:0] x);
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    @(negedge clk);
    chk("chan_fire", chan_fire, x);
  endtask : pulse
  initial begin
    rst = 1'b1;
    trig = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc("interval", REG_INTERVAL, 32'h0);
    rc("length", REG_LENGTH, 32'h100);
    rc("dur", REG_DUR_LO, 32'hC800);
    rc("ctrl", REG_CTRL, 32'h2);
    rc("chan_en", REG_CHAN_EN, 32'hF);
    rc("unmapped", 8'h34, 32'h0);
    chk("slverr", e, 1'b1);
    for (int i = 0; i < 9; i++) begin
      wr(REG_INTERVAL, iv[i]);
      rc("interval", REG_INTERVAL, {27'h0, ix[i]});
      chk("slverr", e, 1'b0);
      ctl.xfer(1'b0, REG_CTRL, 32'h0, q, e);
      chk("rt", q[1], ix[i] < 5'h08);
    end
    rc("status", REG_STATUS, 32'h1);
    wr(REG_STATUS, 32'hF);
    wr(REG_LENGTH, 32'h7530);
    rc("length", REG_LENGTH, 32'h7530);
    rc("dur", REG_DUR_LO, 32'hB2D05E00);
    wr(REG_INTERVAL, 32'h00030028);
    rc("length", REG_LENGTH, 32'h3A98);
    rc("dur", REG_DUR_LO, 32'h23C34600);
    wr(REG_LENGTH, 32'h7530);
    wr(REG_LENGTH, 32'h00FF);
    rc("length", REG_LENGTH, 32'h3A98);
    rc("status", REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'hF);
    // interval and length go first, duration last
    wr(REG_INTERVAL, 32'h00030001);
    wr(REG_LENGTH, 32'h03E8);
    wr(REG_DUR_LO, 32'h00325AA0);
    wr(REG_DUR_HI, 32'h0);
    rc("interval", REG_INTERVAL, 32'h4);
    rc("dur", REG_DUR_LO, 32'h003D0900);
    wr(REG_DUR_LO, 32'h0000C7FF);
    wr(REG_DUR_HI, 32'h0);
    rc("dur", REG_DUR_LO, 32'h003D0900);
    wr(REG_INTERVAL, 32'h00030001);
    wr(REG_ANCHOR, 32'h00010032);
    rc("anchor", REG_ANCHOR, 32'h1388);
    wr(REG_ANCHOR, 32'h00002711);
    rc("status", REG_STATUS, 32'hC);
    wr(REG_OFS_T_LO, 32'h000927C0);
    wr(REG_OFS_T_HI, 32'h0);
    rc("first", REG_FIRST_LO, 32'h0);
    wr(REG_OFS_PTS, 32'hFFFFFDA8);
    rc("first", REG_FIRST_LO, 32'hFFF0BDC0);
    wr(REG_CHAN_EN, 32'h5);
    wr(REG_CTRL, 32'h1);
    // start pulse is registered, look once it has settled
    @(negedge clk);
    chk("acq_start", acq_start, 1'b1);
    rc("ctrl", REG_CTRL, 32'h3);
    chk("acq_start", acq_start, 1'b0);
    wr(REG_LENGTH, 32'h07D0);
    chk("acq_len", acq_len, 16'h03E8);
    chk("acq_step", acq_step, 5'h02);
    chk("acq_rt", acq_rt, 1'b1);
    chk("first", acq_first_time, 64'hFFFFFFFFFFF0BDC0);
    pulse(4'h5);
    pulse(4'h0);
    finish_test();
  end
endmodule : awp_window_positioner_tb
